/* File: logic/udcr_pkg.sv */
package udcr_pkg;
    localparam int ADDR_W = 12;
    localparam int BURST_W = 8;
    localparam logic [11:0] CFG0_OFS = 12'h080;
    // Field positions
    localparam int B_LPM = 30;
    localparam int B_SUSP = 29;
    localparam int B_SPD = 13;
    localparam int B_UTX = 10;
    localparam int B_URX = 9;
    localparam int B_BIR = 6;
    localparam int B_BCE = 5;
    localparam int B_SWAP = 4;
    localparam int B_RWK = 2;
    localparam int B_PWR = 1;
    localparam int B_SBP = 0;
    // Byte lanes holding writable fields
    localparam int L_HI = 3;
    localparam int L_MID = 1;
    localparam int L_LO = 0;
    localparam logic [2:0] SPD_HS = 3'h0;
    localparam logic [2:0] SPD_FS = 3'h1;
    // Image flag indices
    localparam int F_LPM = 0;
    localparam int F_SUSP = 1;
    localparam int F_SWAP = 2;
    localparam int F_RWK = 3;
    localparam int F_PWR = 4;
    localparam int F_W = 5;
    // Defaults when no image exists: pwr, rwk, swap, susp, lpm
    localparam logic [4:0] IMG_DEF = 5'h1b;
    localparam logic [31:0] RSVD_MASK = 32'h9fff1988;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : udcr_pkg

/* File: logic/udcr_axil_slave.sv */
`timescale 1ns/1ps
module udcr_axil_slave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic [udcr_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // Read channels
    input wire logic [udcr_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Register side
    output logic wr_en,
    output logic [udcr_pkg::ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [udcr_pkg::ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_have_q;
    logic w_have_q;

    assign awready = !aw_have_q && !bvalid;
    assign wready = !w_have_q && !bvalid;
    assign wr_en = aw_have_q && w_have_q && !bvalid;
    assign arready = !rvalid;
    assign rd_en = arvalid && arready;
    assign rd_addr = araddr;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_have_q <= 1'b1;
            wr_addr <= awaddr;
        end else if (wr_en) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_have_q <= 1'b0;
            wr_data <= '0;
            wr_strb <= '0;
        end else if (wvalid && wready) begin
            w_have_q <= 1'b1;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_en) begin
            w_have_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= udcr_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? udcr_pkg::RESP_SLVERR : udcr_pkg::RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= udcr_pkg::RESP_OKAY;
        end else if (rd_en) begin
            rvalid <= 1'b1;
            rdata <= rd_err ? 32'h0 : rd_data;
            rresp <= rd_err ? udcr_pkg::RESP_SLVERR : udcr_pkg::RESP_OKAY;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule : udcr_axil_slave

/* File: logic/udcr_usb_config_zero.sv */
`timescale 1ns/1ps
// Function
// [RULE1] Bit 30 enables link power management support.
// [RULE2] Bit 29 low blocks suspend; high lets suspend conditions suspend the PHY.
// [RULE3] Bits 15:13 pick connect speed: 000 high, 001 full; default 000.
// [RULE4] Writing 1 to bit 10 pulses bulk-in transmitter reset, reads 0; code reads 1 in the pulse cycle.
// [RULE5] Writing 1 to bit 9 pulses bulk-out receiver reset, reads 0; code reads 1 in the pulse cycle.
// [RULE6] IN token on empty FIFO: ZLP if bit 6 clear, NAK if set.
// [RULE7] Bit 5 applies the burst-limit value; clear ignores it.
// [RULE8] Read-only bit 4 reports whether D+ and D- pins are swapped.
// [RULE9] Remote wakeup supported only while bit 2 is set.
// [RULE10] Bit 1 reports power: 0 bus powered, 1 self powered.
// [RULE11] Sync loss stalls bulk-out pipe unless bit 0 is set; default 0.
// [RULE12] Suspend allow loads from EEPROM, else OTP, else 1; restored on resets.
// [RULE13] Line swap loads from EEPROM, else OTP, else 0; restored on resets.
// [RULE14] LPM and remote wake load EEPROM, else OTP, else 1; restored on resets.
// [RULE15] Power source loads from EEPROM only, else 1; restored on resets.
// [RULE16] Protected fields keep their value across resets while protection is on.
// [RULE17] Empty-reply select and burst-limit enable are read/write, reset 0.
// [RULE18] Reserved bits read zero and ignore writes.
module udcr_usb_config_zero (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [udcr_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [udcr_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Configuration image loader
    input wire logic img_load,
    input wire logic eeprom_present,
    input wire logic otp_configured,
    input wire logic [udcr_pkg::F_W-1:0] ee_flags,
    input wire logic [udcr_pkg::F_W-1:0] otp_flags,
    // Reset events
    input wire logic usb_reset,
    input wire logic lite_reset,
    input wire logic reset_protect,
    // USB core
    input wire logic suspend_cond,
    output logic phy_suspend_n,
    output logic lpm_enable,
    output logic [2:0] connect_speed_sel,
    output logic bulk_in_transmitter_rst,
    output logic bulk_out_receiver_rst,
    input wire logic in_token,
    input wire logic rx_fifo_empty,
    output logic in_reply_zlp,
    output logic in_reply_nak,
    input wire logic [udcr_pkg::BURST_W-1:0] burst_cap,
    output logic [udcr_pkg::BURST_W-1:0] tx_burst_limit,
    output logic burst_limit_active,
    output logic line_swap,
    output logic remote_wake_support,
    output logic self_powered,
    input wire logic sync_loss,
    output logic bulk_out_stall
);
    logic wr_en;
    logic [udcr_pkg::ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic rd_en;
    logic [udcr_pkg::ADDR_W-1:0] rd_addr;
    logic [31:0] rd_word;
    logic wr_hit;
    logic rst_evt;
    logic restore;
    logic [udcr_pkg::F_W-1:0] img_sel;
    logic [udcr_pkg::F_W-1:0] img_q;
    logic lpm_q;
    logic susp_q;
    logic [2:0] spd_q;
    logic utx_q;
    logic urx_q;
    logic bir_q;
    logic bce_q;
    logic swap_q;
    logic rwk_q;
    logic pwr_q;
    logic sbp_q;

    function automatic logic hit(input logic [udcr_pkg::ADDR_W-1:0] a);
        hit = (a[udcr_pkg::ADDR_W-1:2] == udcr_pkg::CFG0_OFS[udcr_pkg::ADDR_W-1:2]);
    endfunction : hit

    function automatic logic lane(input int l);
        lane = wr_hit && wr_strb[l];
    endfunction : lane

    udcr_axil_slave u_slave (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(!hit(wr_addr)),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_word),
        .rd_err(!hit(rd_addr))
    );

    assign wr_hit = wr_en && hit(wr_addr);
    assign rst_evt = usb_reset || lite_reset;
    assign restore = rst_evt && !reset_protect; // RULE16

    // Image value: EEPROM first, then OTP (except power), then fixed default
    always_comb begin
        for (int i = 0; i < udcr_pkg::F_W; i++) begin
            if (eeprom_present) begin
                img_sel[i] = ee_flags[i];
            end else if (otp_configured) begin
                img_sel[i] = otp_flags[i];
            end else begin
                img_sel[i] = udcr_pkg::IMG_DEF[i];
            end
        end
        if (!eeprom_present) begin
            img_sel[udcr_pkg::F_PWR] = udcr_pkg::IMG_DEF[udcr_pkg::F_PWR]; // RULE15
        end
    end

    // Last loaded image, source for reset restoration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            img_q <= udcr_pkg::IMG_DEF;
        end else if (img_load) begin
            img_q <= img_sel; // RULE12 RULE13 RULE14 RULE15
        end
    end

    // Protected fields: image load, then reset event, then software write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lpm_q <= udcr_pkg::IMG_DEF[udcr_pkg::F_LPM];
            susp_q <= udcr_pkg::IMG_DEF[udcr_pkg::F_SUSP];
            rwk_q <= udcr_pkg::IMG_DEF[udcr_pkg::F_RWK];
            pwr_q <= udcr_pkg::IMG_DEF[udcr_pkg::F_PWR];
            spd_q <= udcr_pkg::SPD_HS;
        end else if (img_load) begin
            lpm_q <= img_sel[udcr_pkg::F_LPM]; // RULE14
            susp_q <= img_sel[udcr_pkg::F_SUSP]; // RULE12
            rwk_q <= img_sel[udcr_pkg::F_RWK]; // RULE14
            pwr_q <= img_sel[udcr_pkg::F_PWR]; // RULE15
            spd_q <= udcr_pkg::SPD_HS; // RULE3
        end else if (restore) begin
            lpm_q <= img_q[udcr_pkg::F_LPM]; // RULE14
            susp_q <= img_q[udcr_pkg::F_SUSP]; // RULE12
            rwk_q <= img_q[udcr_pkg::F_RWK]; // RULE14
            pwr_q <= img_q[udcr_pkg::F_PWR]; // RULE15
            spd_q <= udcr_pkg::SPD_HS; // RULE3
        end else begin
            if (lane(udcr_pkg::L_HI)) begin
                lpm_q <= wr_data[udcr_pkg::B_LPM]; // RULE1
                susp_q <= wr_data[udcr_pkg::B_SUSP]; // RULE2
            end
            if (lane(udcr_pkg::L_MID)) begin
                spd_q <= wr_data[udcr_pkg::B_SPD+:3]; // RULE3
            end
            if (lane(udcr_pkg::L_LO)) begin
                rwk_q <= wr_data[udcr_pkg::B_RWK]; // RULE9
                pwr_q <= wr_data[udcr_pkg::B_PWR]; // RULE10
            end
        end
    end

    // Line swap is read-only; only image and reset events move it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_q <= udcr_pkg::IMG_DEF[udcr_pkg::F_SWAP];
        end else if (img_load) begin
            swap_q <= img_sel[udcr_pkg::F_SWAP]; // RULE13
        end else if (rst_evt) begin
            swap_q <= img_q[udcr_pkg::F_SWAP]; // RULE13
        end
    end

    // Plain software fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bir_q <= 1'b0;
            bce_q <= 1'b0;
            sbp_q <= 1'b0;
        end else if (lane(udcr_pkg::L_LO)) begin
            bir_q <= wr_data[udcr_pkg::B_BIR]; // RULE17
            bce_q <= wr_data[udcr_pkg::B_BCE]; // RULE17
            sbp_q <= wr_data[udcr_pkg::B_SBP]; // RULE11
        end
    end

    // Self-clearing datapath resets, one cycle each
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            utx_q <= 1'b0;
            urx_q <= 1'b0;
        end else begin
            utx_q <= lane(udcr_pkg::L_MID) && wr_data[udcr_pkg::B_UTX]; // RULE4
            urx_q <= lane(udcr_pkg::L_MID) && wr_data[udcr_pkg::B_URX]; // RULE5
        end
    end

    // Suspend request toward the PHY
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phy_suspend_n <= 1'b1;
        end else begin
            phy_suspend_n <= !(suspend_cond && susp_q); // RULE2
        end
    end

    // Reply to IN on an empty receive FIFO
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_reply_zlp <= 1'b0;
            in_reply_nak <= 1'b0;
        end else begin
            in_reply_zlp <= in_token && rx_fifo_empty && !bir_q; // RULE6
            in_reply_nak <= in_token && rx_fifo_empty && bir_q; // RULE6
        end
    end

    // Burst limit applied to the transmitter
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_burst_limit <= '0;
        end else begin
            tx_burst_limit <= bce_q ? burst_cap : '0; // RULE7
        end
    end

    // Bulk-out stall on loss of sync
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bulk_out_stall <= 1'b0;
        end else begin
            bulk_out_stall <= sync_loss && !sbp_q; // RULE11
        end
    end

    assign lpm_enable = lpm_q; // RULE1
    assign connect_speed_sel = spd_q; // RULE3
    assign bulk_in_transmitter_rst = utx_q;
    assign bulk_out_receiver_rst = urx_q;
    assign burst_limit_active = bce_q; // RULE7
    assign line_swap = swap_q; // RULE8
    assign remote_wake_support = rwk_q; // RULE9
    assign self_powered = pwr_q; // RULE10

    always_comb begin
        rd_word = '0; // RULE18
        rd_word[udcr_pkg::B_LPM] = lpm_q;
        rd_word[udcr_pkg::B_SUSP] = susp_q;
        rd_word[udcr_pkg::B_SPD+:3] = spd_q;
        rd_word[udcr_pkg::B_UTX] = utx_q;
        rd_word[udcr_pkg::B_URX] = urx_q;
        rd_word[udcr_pkg::B_BIR] = bir_q;
        rd_word[udcr_pkg::B_BCE] = bce_q;
        rd_word[udcr_pkg::B_SWAP] = swap_q; // RULE8
        rd_word[udcr_pkg::B_RWK] = rwk_q;
        rd_word[udcr_pkg::B_PWR] = pwr_q;
        rd_word[udcr_pkg::B_SBP] = sbp_q;
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    logic quiet;
    assign quiet = !img_load && !restore;

    property p_lpm_write;
        (lane(udcr_pkg::L_HI) && quiet) |=> (lpm_enable == $past(wr_data[udcr_pkg::B_LPM]));
    endproperty
    a_lpm_write: assert property (p_lpm_write) else $error("lpm enable missed write"); // RULE1

    property p_susp_block;
        (!susp_q && !img_load && !restore && !wr_en) |=> phy_suspend_n [*2];
    endproperty
    a_susp_block: assert property (p_susp_block) else $error("suspend asserted while blocked"); // RULE2

    property p_susp_go;
        (suspend_cond && susp_q) |=> !phy_suspend_n;
    endproperty
    a_susp_go: assert property (p_susp_go) else $error("suspend not asserted"); // RULE2

    property p_speed;
        (lane(udcr_pkg::L_MID) && quiet) |=> (connect_speed_sel == $past(wr_data[udcr_pkg::B_SPD+:3]));
    endproperty
    a_speed: assert property (p_speed) else $error("speed field missed write"); // RULE3

    property p_utx_pulse;
        (lane(udcr_pkg::L_MID) && wr_data[udcr_pkg::B_UTX]) |=> bulk_in_transmitter_rst ##1 !utx_q;
    endproperty
    a_utx_pulse: assert property (p_utx_pulse) else $error("transmitter reset not one pulse"); // RULE4

    property p_urx_pulse;
        (lane(udcr_pkg::L_MID) && wr_data[udcr_pkg::B_URX]) |=> bulk_out_receiver_rst ##1 !urx_q;
    endproperty
    a_urx_pulse: assert property (p_urx_pulse) else $error("receiver reset not one pulse"); // RULE5

    property p_in_reply;
        (in_token && rx_fifo_empty) |=> (in_reply_nak == $past(bir_q)) && (in_reply_zlp != in_reply_nak);
    endproperty
    a_in_reply: assert property (p_in_reply) else $error("wrong empty IN reply"); // RULE6

    property p_burst_off;
        !bce_q |=> (tx_burst_limit == '0);
    endproperty
    a_burst_off: assert property (p_burst_off) else $error("burst limit used while disabled"); // RULE7

    property p_swap_ro;
        (wr_hit && !img_load && !rst_evt) |=> $stable(line_swap);
    endproperty
    a_swap_ro: assert property (p_swap_ro) else $error("line swap changed by write"); // RULE8

    property p_stall;
        sync_loss |=> (bulk_out_stall == !$past(sbp_q));
    endproperty
    a_stall: assert property (p_stall) else $error("wrong stall on sync loss"); // RULE11

    property p_restore;
        (restore && !img_load) |=> (susp_q == $past(img_q[udcr_pkg::F_SUSP])) && (rwk_q == $past(img_q[udcr_pkg::F_RWK]));
    endproperty
    a_restore: assert property (p_restore) else $error("reset event did not restore image"); // RULE12

    property p_pwr_no_ee;
        (img_load && !eeprom_present) |=> self_powered;
    endproperty
    a_pwr_no_ee: assert property (p_pwr_no_ee) else $error("power default wrong without EEPROM"); // RULE15

    property p_protect;
        (rst_evt && reset_protect && !img_load && !wr_hit) |=> $stable(lpm_q) && $stable(spd_q) && $stable(pwr_q);
    endproperty
    a_protect: assert property (p_protect) else $error("protected field changed on reset"); // RULE16

    property p_rsvd;
        rvalid |-> ((rdata & udcr_pkg::RSVD_MASK) == 32'h0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read non-zero"); // RULE18

    c_nak: cover property (in_token && rx_fifo_empty && bir_q);
    c_stall: cover property (sync_loss && !sbp_q);
    c_restore: cover property (restore);
    c_write: cover property (wr_hit ##[1:4] bvalid && bready);
endmodule : udcr_usb_config_zero

/* File: sim/udcr_tb_top.sv */
`timescale 1ns/1ps
module udcr_tb_top;
    localparam logic [11:0] A_CFG = udcr_pkg::CFG0_OFS;
    localparam logic [11:0] A_BAD = 12'h084;
    localparam logic [1:0] OK = udcr_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = udcr_pkg::RESP_SLVERR;
    // Ordinary cases: write data, strobes, expected readback
    localparam logic [31:0] ROW_D [7] = '{32'hffffffff, 32'h9fff1988, 32'hffffffff, 32'hffffffff,
        32'h00002000, 32'h00000000, 32'h60000006};
    localparam logic [3:0] ROW_S [7] = '{4'hf, 4'hf, 4'h1, 4'h8, 4'h2, 4'h4, 4'hf};
    localparam logic [31:0] ROW_E [7] = '{32'h6000e067, 32'h00000000, 32'h00000067, 32'h60000067,
        32'h60002067, 32'h60002067, 32'h60000006};
    // Clock, reset and bus
    logic aclk, aresetn;
    logic [udcr_pkg::ADDR_W-1:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    // Image and reset events
    logic img_load, eeprom_present, otp_configured, usb_reset, lite_reset, reset_protect;
    logic [udcr_pkg::F_W-1:0] ee_flags, otp_flags;
    // USB core side
    logic suspend_cond, phy_suspend_n, lpm_enable, bulk_in_transmitter_rst, bulk_out_receiver_rst;
    logic [2:0] connect_speed_sel;
    logic in_token, rx_fifo_empty, in_reply_zlp, in_reply_nak, burst_limit_active, line_swap;
    logic [udcr_pkg::BURST_W-1:0] burst_cap, tx_burst_limit;
    logic remote_wake_support, self_powered, sync_loss, bulk_out_stall;
    int num_errors, samples_checked, n_tx, n_rx, n_zlp, n_nak, n_stall, i;

    udcr_usb_config_zero i_udcr_usb_config_zero (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .img_load(img_load), .eeprom_present(eeprom_present),
        .otp_configured(otp_configured), .ee_flags(ee_flags), .otp_flags(otp_flags), .usb_reset(usb_reset),
        .lite_reset(lite_reset), .reset_protect(reset_protect), .suspend_cond(suspend_cond),
        .phy_suspend_n(phy_suspend_n), .lpm_enable(lpm_enable), .connect_speed_sel(connect_speed_sel),
        .bulk_in_transmitter_rst(bulk_in_transmitter_rst), .bulk_out_receiver_rst(bulk_out_receiver_rst),
        .in_token(in_token), .rx_fifo_empty(rx_fifo_empty), .in_reply_zlp(in_reply_zlp),
        .in_reply_nak(in_reply_nak), .burst_cap(burst_cap), .tx_burst_limit(tx_burst_limit),
        .burst_limit_active(burst_limit_active), .line_swap(line_swap),
        .remote_wake_support(remote_wake_support), .self_powered(self_powered), .sync_loss(sync_loss),
        .bulk_out_stall(bulk_out_stall)
    );

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Pulse counters for the one-cycle strobes
    always @(posedge aclk) begin
        if (bulk_in_transmitter_rst === 1'b1) n_tx++;
        if (bulk_out_receiver_rst === 1'b1) n_rx++;
        if (in_reply_zlp === 1'b1) n_zlp++;
        if (in_reply_nak === 1'b1) n_nak++;
        if (bulk_out_stall === 1'b1) n_stall++;
    end

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: response got %h expected %h", $time, got, exp);
        end
    endtask : check_resp

    task automatic timed_out;
        num_errors++;
        $display("MISMATCH at %0t: wait expired got %h expected %h", $time, 1'b0, 1'b1);
        wrap_up();
    endtask : timed_out

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        logic got;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        got = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (awvalid && awready === 1'b1) begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready === 1'b1) begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
            if (aw_ok && w_ok && !awvalid && !wvalid && bvalid === 1'b1) begin
                got = 1'b1;
                bready <= 1'b0;
                check_resp(bresp, er);
            end
        end
        if (!got) timed_out();
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        logic got;
        got = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge aclk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (!arvalid && rvalid === 1'b1) begin
                got = 1'b1;
                rready <= 1'b0;
                check_word(rdata, ed);
                check_resp(rresp, er);
            end
        end
        if (!got) timed_out();
    endtask : axi_read

    task automatic idle(input int n);
        repeat (n) @(posedge aclk);
    endtask : idle

    // One-cycle strobe: 0 token, 1 sync loss, 2 image load, 3 usb reset, 4 lite reset
    task automatic strobe(input int sel);
        @(posedge aclk);
        case (sel)
            0: in_token <= 1'b1;
            1: sync_loss <= 1'b1;
            2: img_load <= 1'b1;
            3: usb_reset <= 1'b1;
            default: lite_reset <= 1'b1;
        endcase
        @(posedge aclk);
        in_token <= 1'b0;
        sync_loss <= 1'b0;
        img_load <= 1'b0;
        usb_reset <= 1'b0;
        lite_reset <= 1'b0;
        idle(3);
    endtask : strobe

    initial begin
        {awaddr, araddr, wdata, wstrb, awvalid, wvalid, bready, arvalid, rready} = '0;
        {img_load, eeprom_present, otp_configured, ee_flags, otp_flags} = '0;
        {usb_reset, lite_reset, reset_protect, suspend_cond, in_token, sync_loss} = '0;
        rx_fifo_empty = 1'b1;
        burst_cap = 8'h5a;
        {num_errors, samples_checked, n_tx, n_rx, n_zlp, n_nak, n_stall} = '0;
        aresetn = 1'b0;
        idle(4);
        aresetn <= 1'b1;
        axi_read(A_CFG, 32'h60000006, OK);
        check_word({31'h0, line_swap}, 32'h0);
        $display("reset test done");
        for (i = 0; i < 7; i++) begin
            axi_write(A_CFG, ROW_D[i], ROW_S[i], OK);
            axi_read(A_CFG, ROW_E[i], OK);
            idle(2);
            check_word({31'h0, lpm_enable}, {31'h0, ROW_E[i][30]});
            check_word({29'h0, connect_speed_sel}, {29'h0, ROW_E[i][15:13]});
            check_word({31'h0, burst_limit_active}, {31'h0, ROW_E[i][5]});
            check_word({31'h0, remote_wake_support}, {31'h0, ROW_E[i][2]});
            check_word({31'h0, self_powered}, {31'h0, ROW_E[i][1]});
            check_word({31'h0, phy_suspend_n}, 32'h1);
        end
        $display("row test done");
        axi_write(A_BAD, 32'hffffffff, 4'hf, ERR);
        axi_read(A_BAD, 32'h0, ERR);
        axi_read(A_CFG, 32'h60000006, OK);
        axi_write(A_CFG, 32'h60000606, 4'hf, OK);
        idle(2);
        check_word(n_tx, 32'h2);
        check_word(n_rx, 32'h2);
        axi_read(A_CFG, 32'h60000006, OK);
        axi_write(A_CFG, 32'h60000206, 4'hf, OK);
        idle(2);
        check_word(n_tx, 32'h2);
        check_word(n_rx, 32'h3);
        $display("self-clear test done");
        strobe(0);
        check_word(n_zlp, 32'h1);
        check_word(n_nak, 32'h0);
        axi_write(A_CFG, 32'h60000046, 4'hf, OK);
        strobe(0);
        check_word(n_zlp, 32'h1);
        check_word(n_nak, 32'h1);
        rx_fifo_empty <= 1'b0;
        strobe(0);
        check_word(n_nak, 32'h1);
        check_word(n_zlp, 32'h1);
        rx_fifo_empty <= 1'b1;
        axi_write(A_CFG, 32'h60000066, 4'hf, OK);
        idle(2);
        check_word({24'h0, tx_burst_limit}, 32'h5a);
        axi_write(A_CFG, 32'h60000046, 4'hf, OK);
        idle(2);
        check_word({24'h0, tx_burst_limit}, 32'h0);
        strobe(1);
        check_word(n_stall, 32'h1);
        axi_write(A_CFG, 32'h60000047, 4'hf, OK);
        strobe(1);
        check_word(n_stall, 32'h1);
        suspend_cond <= 1'b1;
        idle(3);
        check_word({31'h0, phy_suspend_n}, 32'h0);
        axi_write(A_CFG, 32'h40000047, 4'hf, OK);
        idle(3);
        check_word({31'h0, phy_suspend_n}, 32'h1);
        suspend_cond <= 1'b0;
        $display("core strobe test done");
        eeprom_present <= 1'b1;
        ee_flags <= 5'h04;
        strobe(2);
        axi_read(A_CFG, 32'h00000051, OK);
        check_word({31'h0, line_swap}, 32'h1);
        axi_write(A_CFG, 32'hffffffff, 4'hf, OK);
        strobe(3);
        axi_read(A_CFG, 32'h00000071, OK);
        reset_protect <= 1'b1;
        axi_write(A_CFG, 32'h6000e067, 4'hf, OK);
        strobe(4);
        axi_read(A_CFG, 32'h6000e077, OK);
        reset_protect <= 1'b0;
        eeprom_present <= 1'b0;
        otp_configured <= 1'b1;
        otp_flags <= 5'h0a;
        ee_flags <= 5'h1f;
        strobe(2);
        axi_read(A_CFG, 32'h20000067, OK);
        otp_configured <= 1'b0;
        strobe(2);
        axi_read(A_CFG, 32'h60000067, OK);
        $display("image test done");
        @(posedge aclk);
        aresetn <= 1'b0;
        idle(4);
        aresetn <= 1'b1;
        axi_read(A_CFG, 32'h60000006, OK);
        $display("second reset test done");
        wrap_up();
    end
endmodule : udcr_tb_top
